/* hdl/lcd_i2c_target.sv */
// Two-wire bus target, display RAM and common/segment scan of the LCD controller.
//
// Summary of operation
// - Drive 44 segments from phase and display latch.
// - Drive 4 commons following selected drive mode.
// - Target only; never makes START, STOP, clock.
// - SDA changes only while SCL is low.
// - SDA falling while SCL high is START.
// - SDA rising while SCL high is STOP.
// - Busy from START; repeated START equals START.
// - Bytes are eight bits MSB first, plus acknowledge.
// - Acknowledge received bytes low through ninth pulse.
// - First byte: seven-bit address plus direction bit.
// - Acknowledge address byte only when it matches.
// - Command write: address, register, data; all acknowledged.
// - Byte after a mode-set, blink or voltage command is discarded.
// - Page write loads pointer, stores, increments.
// - Pointer wraps from 15H to 00H.
// - Master acknowledge advances pointer, next byte sent.
// - Sequential reads continue until master NACK or STOP.
// - Mode-set fields decoded; default value 80H.
// - Fixed 1/4 duty; bias 1/2 or 1/3.
// - Frame rate, oscillator, display, bias decoded.
// - Power-on: 1/3 bias, display off, 80 Hz.
// - Undefined commands change nothing.
`timescale 1ns/100ps
`include "lcd_cfg.svh"

module lcd_i2c_target
  import lcd_pkg::*;
#(
  parameter int SEG_N = 44,
  parameter int RAM_DEPTH = 22,
  parameter int PHASE_CYC = `LCD_PHASE_SLOW_NS / `LCD_SYS_CLK_NS
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Two-wire bus pins; SCL also clocks the bit sampler.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Display drive.
  output logic [SEG_N-1:0] segment_outputs_o,
  output logic [3:0] common_outputs_o,
  output logic frame_invert_o,
  // Mode status.
  output lcd_mode_t mode_o,
  output logic bus_busy_o
);

  // Refuse sizes that the RAM mapping or scan timer cannot serve.
  generate
    if (SEG_N != 2 * RAM_DEPTH || RAM_DEPTH != 22 || PHASE_CYC < 4) begin : g_bad
      $error("lcd_i2c_target: unsupported parameter values.");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Link domain: SCL rising edge samples SDA and toggles a flag.
  // ---------------------------------------------------------------
  logic link_bit; // SDA as sampled at the last SCL rise.
  logic link_tgl; // Flips once per SCL rise.

  // The sampled bit stays put until the next SCL rise, a full bit time away.
  always_ff @(posedge scl_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      link_bit <= 1'b1;
      link_tgl <= 1'b0;
    end else begin
      link_bit <= sda_i;
      link_tgl <= ~link_tgl;
    end
  end

  // ---------------------------------------------------------------
  // System domain: synchronisers for pins and the bit toggle.
  // ---------------------------------------------------------------
  logic scl_m, scl_s, scl_d; // SCL first stage, synced, delayed.
  logic sda_m, sda_s, sda_d; // SDA first stage, synced, delayed.
  logic tgl_m, tgl_s, tgl_d; // Bit toggle first stage, synced, delayed.

  // Two flip-flops before any system-clock logic reads a pin.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      tgl_m <= 1'b0;
      tgl_s <= 1'b0;
      tgl_d <= 1'b0;
    end else begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_d <= sda_s;
      tgl_m <= link_tgl;
      tgl_s <= tgl_m;
      tgl_d <= tgl_s;
    end
  end

  // Bus events seen in the system domain.
  logic scl_fall; // SCL went low.
  logic bit_evt;  // A new bit has been sampled by the link domain.
  logic start_evt;
  logic stop_evt;
  assign scl_fall = scl_d & ~scl_s;
  assign bit_evt = tgl_s ^ tgl_d;
  assign start_evt = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_evt = scl_s & scl_d & ~sda_d & sda_s;

  // ---------------------------------------------------------------
  // Byte engine state.
  // ---------------------------------------------------------------
  lcd_state_t state;
  lcd_wmode_t wmode;    // Meaning of the next written byte.
  logic [7:0] rx_sh;    // Receive shift register.
  logic [7:0] tx_sh;    // Transmit shift register.
  logic [2:0] bit_cnt;  // Bits handled in the current byte.
  logic byte_full;      // Eight bits received.
  logic first_byte;     // Next full byte is the address byte.
  logic read_dir;       // Current transfer is a read.
  logic master_ack;     // Master acknowledged the last sent byte.
  logic [4:0] ptr;      // Display RAM address pointer.
  logic [7:0] ram [RAM_DEPTH]; // Display RAM.
  lcd_mode_t mode;      // Mode settings.
  logic busy;

  // Next pointer value with wrap after the last address.
  logic [4:0] ptr_inc;
  assign ptr_inc = (ptr == `LCD_PTR_MAX) ? `LCD_PTR_ZERO : ptr + 5'h01;

  // Byte just received, including the bit that completes it.
  logic addr_match;
  assign addr_match = (rx_sh[7:1] == `LCD_TARGET_ADDR);

  // Bus busy flag: set at START, cleared at STOP.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy <= 1'b0;
    end else if (start_evt) begin
      busy <= 1'b1;
    end else if (stop_evt) begin
      busy <= 1'b0;
    end
  end

  // Main bus sequencer; the device only follows the master's clock.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= LCD_ST_IDLE;
      wmode <= LCD_WM_NONE;
      rx_sh <= 8'h00;
      tx_sh <= 8'hFF;
      bit_cnt <= 3'h0;
      byte_full <= 1'b0;
      first_byte <= 1'b0;
      read_dir <= 1'b0;
      master_ack <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (start_evt) begin
      // A repeated START restarts exactly like a fresh one.
      state <= LCD_ST_RX;
      bit_cnt <= 3'h0;
      byte_full <= 1'b0;
      first_byte <= 1'b1;
      sda_oe_o <= 1'b0;
    end else if (stop_evt) begin
      // STOP ends any transfer, including sequential reads.
      state <= LCD_ST_IDLE;
      sda_oe_o <= 1'b0;
    end else begin
      case (state)
        LCD_ST_IDLE: begin
          // Unaddressed or finished: SDA stays released.
          sda_oe_o <= 1'b0;
        end
        LCD_ST_RX: begin
          if (bit_evt && !byte_full) begin
            // Bits arrive MSB first.
            rx_sh <= {rx_sh[6:0], link_bit};
            bit_cnt <= bit_cnt + 3'h1;
            byte_full <= (bit_cnt == 3'h7);
          end else if (scl_fall && byte_full) begin
            byte_full <= 1'b0;
            bit_cnt <= 3'h0;
            if (first_byte) begin
              first_byte <= 1'b0;
              if (addr_match) begin
                read_dir <= rx_sh[0];
                wmode <= LCD_WM_CMD;
                sda_oe_o <= 1'b1;
                state <= LCD_ST_RACK;
              end else begin
                state <= LCD_ST_IDLE;
              end
            end else begin
              // Every byte received while addressed is acknowledged.
              sda_oe_o <= 1'b1;
              state <= LCD_ST_RACK;
              case (wmode)
                LCD_WM_CMD: begin
                  if ((rx_sh & `LCD_PTR_CMD_MASK) == `LCD_PTR_CMD_CODE &&
                      rx_sh[4:0] <= `LCD_PTR_MAX) begin
                    wmode <= LCD_WM_DATA;
                  end else if ((rx_sh & `LCD_MODE_MASK) == `LCD_MODE_CODE ||
                               (rx_sh & `LCD_BLINK_MASK) == `LCD_BLINK_CODE ||
                               (rx_sh & `LCD_IVA_MASK) == `LCD_IVA_CODE) begin
                    wmode <= LCD_WM_SKIP;
                  end else begin
                    wmode <= LCD_WM_NONE;
                  end
                end
                LCD_WM_SKIP: begin
                  wmode <= LCD_WM_NONE;
                end
                default: begin
                  wmode <= wmode;
                end
              endcase
            end
          end
        end
        LCD_ST_RACK: begin
          // Hold the acknowledge through the ninth high period; on the fall free it for writes, or drive bit 7 for reads.
          if (scl_fall) begin
            if (read_dir) begin
              tx_sh <= ram[ptr];
              sda_oe_o <= ~ram[ptr][7];
              bit_cnt <= 3'h0;
              state <= LCD_ST_TX;
            end else begin
              sda_oe_o <= 1'b0;
              state <= LCD_ST_RX;
            end
          end
        end
        LCD_ST_TX: begin
          // Shift the next bit out on each SCL fall; release for the ack slot.
          if (scl_fall) begin
            if (bit_cnt == 3'h7) begin
              sda_oe_o <= 1'b0;
              master_ack <= 1'b0;
              state <= LCD_ST_MACK;
            end else begin
              tx_sh <= {tx_sh[6:0], 1'b1};
              sda_oe_o <= ~tx_sh[6];
              bit_cnt <= bit_cnt + 3'h1;
            end
          end
        end
        LCD_ST_MACK: begin
          if (bit_evt) begin
            master_ack <= ~link_bit;
          end else if (scl_fall) begin
            if (master_ack) begin
              // Pointer already advanced; present the following byte.
              tx_sh <= ram[ptr];
              sda_oe_o <= ~ram[ptr][7];
              bit_cnt <= 3'h0;
              state <= LCD_ST_TX;
            end else begin
              state <= LCD_ST_IDLE;
            end
          end
        end
        default: begin
          state <= LCD_ST_IDLE;
        end
      endcase
    end
  end

  // Open-drain: only a low level is ever driven.
  assign sda_o = 1'b0;
  assign bus_busy_o = busy;

  // Write strobe for a data byte, pointer or mode-set command, taken on the byte's last SCL fall.
  logic wr_evt;
  assign wr_evt = (state == LCD_ST_RX) && scl_fall && byte_full && !first_byte;

  // Address pointer: loaded by the pointer command, advanced after writes and acked reads.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ptr <= `LCD_PTR_ZERO;
    end else if (wr_evt && wmode == LCD_WM_CMD &&
                 (rx_sh & `LCD_PTR_CMD_MASK) == `LCD_PTR_CMD_CODE &&
                 rx_sh[4:0] <= `LCD_PTR_MAX) begin
      ptr <= rx_sh[4:0];
    end else if (wr_evt && wmode == LCD_WM_DATA) begin
      ptr <= ptr_inc;
    end else if (state == LCD_ST_MACK && bit_evt && !link_bit) begin
      ptr <= ptr_inc;
    end
  end

  // Display RAM store for page writes.
  always_ff @(posedge sys_clk_i) begin
    if (wr_evt && wmode == LCD_WM_DATA) begin
      ram[ptr] <= rx_sh;
    end
  end

  // Mode register: mode-set command updates all four fields.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // Power-on: 1/3 bias, oscillator and display off, 80 Hz.
      mode <= '{frame_fast: 1'b0, osc_on: 1'b0, disp_on: 1'b0, bias_half: 1'b0};
    end else if (wr_evt && wmode == LCD_WM_CMD &&
                 (rx_sh & `LCD_MODE_MASK) == `LCD_MODE_CODE) begin
      mode.frame_fast <= rx_sh[`LCD_MODE_FRAME_BIT];
      mode.osc_on <= rx_sh[`LCD_MODE_OSC_BIT];
      mode.disp_on <= rx_sh[`LCD_MODE_DISP_BIT] & rx_sh[`LCD_MODE_OSC_BIT];
      mode.bias_half <= rx_sh[`LCD_MODE_BIAS_BIT];
    end
  end
  assign mode_o = mode;

  // ---------------------------------------------------------------
  // Scan: fixed 1/4 duty, one common per phase, inverted each frame.
  // ---------------------------------------------------------------
  localparam int PH_W = $clog2(PHASE_CYC + 1);
  logic [PH_W-1:0] ph_cnt; // Cycles within the current phase.
  logic [PH_W-1:0] ph_len; // Phase length for the selected frame rate.
  logic [1:0] phase;       // Active common.
  assign ph_len = mode.frame_fast ? PH_W'(PHASE_CYC / 2) : PH_W'(PHASE_CYC);

  // Phase timer runs only while the oscillator is on.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ph_cnt <= '0;
      phase <= 2'h0;
      frame_invert_o <= 1'b0;
    end else if (!mode.osc_on) begin
      ph_cnt <= '0;
      phase <= 2'h0;
      frame_invert_o <= 1'b0;
    end else if (ph_cnt >= ph_len - PH_W'(1)) begin
      ph_cnt <= '0;
      phase <= phase + 2'h1;
      if (phase == 2'h3) begin
        frame_invert_o <= ~frame_invert_o;
      end
    end else begin
      ph_cnt <= ph_cnt + PH_W'(1);
    end
  end

  // Common and segment drive; RAM low nibble is the even segment, high the odd one.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      common_outputs_o <= 4'h0;
      segment_outputs_o <= '0;
    end else if (!mode.disp_on) begin
      common_outputs_o <= 4'h0;
      segment_outputs_o <= '0;
    end else begin
      common_outputs_o <= 4'h1 << phase;
      for (int i = 0; i < RAM_DEPTH; i++) begin
        segment_outputs_o[2*i] <= ram[i][phase];
        segment_outputs_o[2*i+1] <= ram[i][3'(phase) + 3'h4];
      end
    end
  end

endmodule : lcd_i2c_target

/* shared/lcd_cfg.svh */
// Constants for the LCD controller two-wire target: codes, field positions, resets, timing.
`ifndef LCD_CFG_SVH
`define LCD_CFG_SVH

// Seven-bit target address matched on the bus; the value is arbitrary.
`define LCD_TARGET_ADDR 7'h2C
// Last display RAM address; the pointer wraps to zero after it.
`define LCD_PTR_MAX 5'h15
`define LCD_PTR_ZERO 5'h00
// Mode-set command: fixed bits and field positions.
`define LCD_MODE_MASK 8'hE2
`define LCD_MODE_CODE 8'h80
`define LCD_MODE_DEFAULT 8'h80
`define LCD_MODE_FRAME_BIT 4
`define LCD_MODE_OSC_BIT 3
`define LCD_MODE_DISP_BIT 2
`define LCD_MODE_BIAS_BIT 0
// Address-pointer command: top three bits zero.
`define LCD_PTR_CMD_MASK 8'hE0
`define LCD_PTR_CMD_CODE 8'h00
// Blink command pattern and voltage-adjust command pattern.
`define LCD_BLINK_MASK 8'hFC
`define LCD_BLINK_CODE 8'hC0
`define LCD_IVA_MASK 8'hC0
`define LCD_IVA_CODE 8'h40
// Clock period of sys_clk_i in ns.
`define LCD_SYS_CLK_NS 4
// One common phase at the 80 Hz frame rate: a quarter of 12.5 ms, in ns.
`define LCD_PHASE_SLOW_NS 3125000

`endif

/* shared/lcd_pkg.sv */
// Types shared by the LCD controller two-wire target.
package lcd_pkg;

  // Mode settings held by the controller.
  typedef struct packed {
    logic frame_fast; // 1 selects 160 Hz frame rate.
    logic osc_on;     // Internal oscillator runs.
    logic disp_on;    // Display enabled.
    logic bias_half;  // 1 selects 1/2 bias, 0 selects 1/3 bias.
  } lcd_mode_t;

  // Bus engine states, one-hot.
  typedef enum logic [4:0] {
    LCD_ST_IDLE = 5'h01,
    LCD_ST_RX = 5'h02,
    LCD_ST_RACK = 5'h04,
    LCD_ST_TX = 5'h08,
    LCD_ST_MACK = 5'h10
  } lcd_state_t;

  // What a received write byte means.
  typedef enum logic [1:0] {
    LCD_WM_CMD = 2'h0,
    LCD_WM_DATA = 2'h1,
    LCD_WM_SKIP = 2'h2,
    LCD_WM_NONE = 2'h3
  } lcd_wmode_t;

endpackage : lcd_pkg

/* verif/lcd_i2c_chk.sv */
// Concurrent checks on the ports of the LCD controller bus target.
`timescale 1ns/100ps
module lcd_i2c_chk
  import lcd_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Bus pins.
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // Display drive and status.
  input wire logic [43:0] segment_outputs_o,
  input wire logic [3:0] common_outputs_o,
  input lcd_mode_t mode_o,
  input wire logic bus_busy_o
);
  // Everything here runs on the system clock and sleeps in reset.
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  // Open-drain data: the device can only pull low.
  sda_low_a: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  // The pull may only move while the clock is low.
  ack_hold_a: assert property ($changed(sda_oe_o) |-> !$past(scl_i, 2))
    else $error("data pull moved while clock high");
  // A falling data edge under a high clock marks the bus busy.
  start_busy_a: assert property (scl_i && $past(scl_i) && $fell(sda_i) |-> ##[1:6] bus_busy_o)
    else $error("start not seen");
  // A rising data edge under a high clock frees the bus.
  stop_free_a: assert property (scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:6] !bus_busy_o)
    else $error("stop not seen");
  // A free bus is never pulled by the device.
  idle_quiet_a: assert property (!bus_busy_o && !$past(bus_busy_o) |-> !sda_oe_o)
    else $error("pull while bus free");
  // Power-on mode: third bias, slow frame, all off.
  mode_reset_a: assert property ($rose(arst_n_i) |-> mode_o == 4'h0)
    else $error("mode not cleared by reset");
  // Mode can change only inside a transfer.
  mode_bus_a: assert property ($changed(mode_o) |-> bus_busy_o)
    else $error("mode changed outside a transfer");
  // The display is never on without the oscillator.
  disp_osc_a: assert property (mode_o.disp_on |-> mode_o.osc_on)
    else $error("display on without oscillator");
  // A lit display scans exactly one common at a time.
  com_hot_a: assert property (mode_o.disp_on && $past(mode_o.disp_on, 2)
    |-> $onehot(common_outputs_o))
    else $error("commons not one-hot");
  // A dark display drives nothing.
  dark_out_a: assert property (!mode_o.disp_on && !$past(mode_o.disp_on, 2)
    |-> common_outputs_o == 4'h0 && segment_outputs_o == '0)
    else $error("outputs active while display off");
endmodule : lcd_i2c_chk

/* verif/lcd_mst_model.sv */
// Two-wire bus master model facing the LCD controller.
`timescale 1ns/100ps
module lcd_mst_model (
  // Wire level seen.
  input wire logic sda_i,
  // Clock driven, and data pull (1 pulls low).
  output logic scl_o,
  output logic sda_pull_o
);
  // Quarter bit in ns; each clock level lasts two, so one bus clock is 80 ns.
  localparam int QT = 20;

  // Idle bus: clock high, data left to the pull-up.
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  // One pulse: data set mid-low, sampled mid-high.
  task automatic clk_bit(input logic b, output logic s);
    #QT sda_pull_o = ~b;
    #QT scl_o = 1'b1;
    #QT s = sda_i;
    #QT scl_o = 1'b0;
  endtask : clk_bit

  // Start or repeated start: data falls under a high clock.
  task automatic start();
    #QT sda_pull_o = 1'b0;
    #QT scl_o = 1'b1;
    #(2*QT) sda_pull_o = 1'b1;
    #(2*QT) scl_o = 1'b0;
  endtask : start

  // Stop: data rises under a high clock, then the bus rests.
  task automatic stop();
    #QT sda_pull_o = 1'b1;
    #QT scl_o = 1'b1;
    #(2*QT) sda_pull_o = 1'b0;
    #(4*QT);
  endtask : stop

  // Byte out, MSB first, then the ninth pulse with data released.
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask : wbyte

  // Byte in, then acknowledge or leave data high to end the read.
  task automatic rbyte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      b[i] = s;
    end
    clk_bit(~ack, s);
  endtask : rbyte
endmodule : lcd_mst_model

/* verif/tb_lcd_driver_i2c_slave.sv */
// Self-checking bench for the LCD controller bus target.
`timescale 1ns/100ps
`include "lcd_cfg.svh"
module tb_lcd_driver_i2c_slave
  import lcd_pkg::*;
;
  localparam int PHASE = 40; // Short common phase for simulation.
  logic sys_clk = 1'b0; // System clock, 4 ns.
  logic arst_n = 1'b0; // Reset, held at start.
  logic scl, pull, sda_oe, sda_out, busy, finv, ack;
  logic [43:0] seg;
  logic [3:0] com;
  lcd_mode_t mode;
  logic [7:0] rd;
  logic fbit; // Frame flag seen during the last common phase.
  int plen; // Cycles that one common stays active.
  logic [7:0] mcode [5] = '{8'h9D, 8'h84, 8'h91, 8'h80, 8'h8C};
  logic [3:0] mexp [5] = '{4'hF, 4'h0, 4'h9, 4'h0, 4'h6};
  logic [7:0] ucode [6] = '{8'hE0, 8'hC1, 8'h45, 8'h16, 8'hA0, 8'h82};
  logic [7:0] d0 = 8'h96; // Lands at address 00H.
  logic [7:0] d1 = 8'h3C; // Lands at address 15H.
  int fails = 0, samples_checked = 0, cycles = 0;
  wire sda = ~(pull | sda_oe); // Open-drain wire with pull-up.

  always #2 sys_clk = ~sys_clk;

  lcd_i2c_target #(.PHASE_CYC(PHASE)) u_dut (
    .sys_clk_i(sys_clk), .arst_n_i(arst_n), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_out), .sda_oe_o(sda_oe), .segment_outputs_o(seg),
    .common_outputs_o(com), .frame_invert_o(finv), .mode_o(mode), .bus_busy_o(busy)
  );
  lcd_mst_model u_mst (.sda_i(sda), .scl_o(scl), .sda_pull_o(pull));

  // Compare one value and count it.
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Addressed write of a byte list, every byte acknowledged.
  task automatic wr(input logic [7:0] b[$]);
    u_mst.start();
    check("busy after start", 8'h1, {7'h0, busy});
    u_mst.wbyte({`LCD_TARGET_ADDR, 1'b0}, ack);
    check("address ack", 8'h1, {7'h0, ack});
    foreach (b[i]) begin
      u_mst.wbyte(b[i], ack);
      check("byte ack", 8'h1, {7'h0, ack});
    end
    u_mst.stop();
    check("busy after stop", 8'h0, {7'h0, busy});
  endtask : wr

  // Set the pointer, repeated start, read a list; last byte not acknowledged.
  task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp[$]);
    u_mst.start();
    u_mst.wbyte({`LCD_TARGET_ADDR, 1'b0}, ack);
    u_mst.wbyte(ptr, ack);
    u_mst.start();
    check("busy at repeated start", 8'h1, {7'h0, busy});
    u_mst.wbyte({`LCD_TARGET_ADDR, 1'b1}, ack);
    check("read address ack", 8'h1, {7'h0, ack});
    foreach (exp[i]) begin
      u_mst.rbyte(i < exp.size() - 1, rd);
      check("read data", exp[i], rd);
    end
    u_mst.stop();
  endtask : rd_chk

  // Print the counts and the verdict, then end the run.
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // Watchdog: the tests need about 10000 cycles.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      $display("CHECK FAILED watchdog expected %0d seen %0d", 29999, cycles);
      final_report();
    end
  end

  // Main sequence.
  initial begin
    repeat (8) @(negedge sys_clk);
    check("mode in reset", 8'h0, {4'h0, mode});
    arst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    // A foreign address is refused and what follows is ignored.
    u_mst.start();
    u_mst.wbyte({`LCD_TARGET_ADDR ^ 7'h01, 1'b0}, ack);
    check("foreign address ack", 8'h0, {7'h0, ack});
    u_mst.wbyte(8'h88, ack);
    check("ignored byte ack", 8'h0, {7'h0, ack});
    u_mst.stop();
    check("mode after foreign", 8'h0, {4'h0, mode});
    $display("test foreign address done");
    // Mode-set codes; the trailing byte must be discarded.
    foreach (mcode[i]) begin
      wr('{mcode[i], 8'h9D});
      check("mode fields", {4'h0, mexp[i]}, {4'h0, mode});
    end
    $display("test mode set done");
    // Undefined, blink, voltage and out-of-range codes leave the mode alone.
    foreach (ucode[i]) begin
      wr('{ucode[i], 8'h9D});
      check("mode kept", 8'h06, {4'h0, mode});
    end
    $display("test other commands done");
    // Page write across the pointer wrap, then sequential read back.
    wr('{8'h14, 8'hA5, d1, d0, 8'h5A});
    rd_chk(8'h14, '{8'hA5, d1, d0, 8'h5A});
    $display("test page write and read done");
    // Each common phase shows the stored bits on the first and last segments.
    for (int k = 0; k < 4; k++) begin
      while (com !== (4'h1 << k)) @(negedge sys_clk);
      repeat (2) @(negedge sys_clk);
      check("segments", {4'h0, d1[4+k], d1[k], d0[4+k], d0[k]},
        {4'h0, seg[43:42], seg[1:0]});
    end
    // The frame flag flips as the last phase hands over; each phase lasts PHASE cycles.
    fbit = finv;
    while (com !== 4'h1) @(negedge sys_clk);
    check("frame invert", {7'h0, ~fbit}, {7'h0, finv});
    plen = 0;
    while (com === 4'h1) begin
      plen++;
      @(negedge sys_clk);
    end
    check("phase length", 8'(PHASE), plen[7:0]);
    $display("test segment scan done");
    final_report();
  end
endmodule : tb_lcd_driver_i2c_slave

bind lcd_i2c_target lcd_i2c_chk u_chk (
  .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .segment_outputs_o(segment_outputs_o),
  .common_outputs_o(common_outputs_o), .mode_o(mode_o), .bus_busy_o(bus_busy_o)
);
